// File: src/rrf_pkg.sv
/*
  Package for the request/response flag framer: flag bit positions,
  error codes, field widths and frame-parse states.
  Assumes byte-wide received data, flag bit N at byte bit N-1.
*/
`default_nettype none
package rrf_pkg;
  // ==========================================================
  // Request flag positions and the response error flag position
  localparam int unsigned SUBCARRIER_BIT = 0;
  localparam int unsigned DATA_RATE_BIT  = 1;
  localparam int unsigned INVENTORY_BIT  = 2;
  localparam int unsigned EXTENSION_BIT  = 3;
  localparam int unsigned FLAG5_BIT      = 4;
  localparam int unsigned FLAG6_BIT      = 5;
  localparam int unsigned OPTION_BIT     = 6;
  localparam int unsigned ERROR_BIT      = 0;
  // ==========================================================
  // Error codes
  localparam logic [7:0] ERR_OPTION     = 8'h03;
  localparam logic [7:0] ERR_GENERIC    = 8'h0f;
  localparam logic [7:0] ERR_NO_BLOCK   = 8'h10;
  localparam logic [7:0] ERR_RELOCK     = 8'h11;
  localparam logic [7:0] ERR_LOCKED     = 8'h12;
  localparam logic [7:0] ERR_PROG_FAIL  = 8'h13;
  localparam logic [7:0] ERR_LOCK_FAIL  = 8'h14;
  localparam logic [7:0] ERR_READ_PROT  = 8'h15;
  // ==========================================================
  // Error cause selectors
  typedef enum logic [2:0] {
    rrf_cause_option, rrf_cause_generic, rrf_cause_no_block,
    rrf_cause_relock, rrf_cause_locked, rrf_cause_prog_fail,
    rrf_cause_lock_fail, rrf_cause_read_prot
  } rrf_cause_type;
  // ==========================================================
  // Widths and counts
  localparam int unsigned UID_BYTES   = 8;
  localparam logic [3:0]  UID_LAST    = 4'h7;
  localparam logic [3:0]  IDX_ZERO    = 4'h0;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [4:0]  SLOTS_MANY  = 5'h10;
  localparam logic [4:0]  SLOTS_ONE   = 5'h01;
  localparam logic [2:0]  SLOT_BITS_MANY = 3'h4;
  localparam logic [2:0]  SLOT_BITS_ONE  = 3'h0;
  // ==========================================================
  // Request parse states
  typedef enum logic [2:0] {
    rrf_idle, rrf_flags, rrf_cmd, rrf_uid, rrf_afi, rrf_body
  } rrf_state_type;
endpackage
`default_nettype wire

// File: src/rrf_err_encode.sv
/*
  Maps an error cause onto its error code byte.
  Assumes the cause is held stable by the caller.
*/
`default_nettype none
module rrf_err_encode
(
  // Cause in
  input  wire rrf_pkg::rrf_cause_type cause,
  // Code out
  output logic [7:0]                  code
);
  // Only listed codes can appear; every cause maps into the set
  always_comb
  begin
    case (cause)
      rrf_pkg::rrf_cause_option:    code = rrf_pkg::ERR_OPTION;    // RULE17
      rrf_pkg::rrf_cause_no_block:  code = rrf_pkg::ERR_NO_BLOCK;  // RULE18
      rrf_pkg::rrf_cause_relock:    code = rrf_pkg::ERR_RELOCK;    // RULE18
      rrf_pkg::rrf_cause_locked:    code = rrf_pkg::ERR_LOCKED;    // RULE19
      rrf_pkg::rrf_cause_prog_fail: code = rrf_pkg::ERR_PROG_FAIL; // RULE19
      rrf_pkg::rrf_cause_lock_fail: code = rrf_pkg::ERR_LOCK_FAIL; // RULE20
      rrf_pkg::rrf_cause_read_prot: code = rrf_pkg::ERR_READ_PROT; // RULE20
      default:                      code = rrf_pkg::ERR_GENERIC;   // RULE21
    endcase
  end
endmodule // rrf_err_encode
`default_nettype wire

// File: src/rrf_uid_cmp.sv
/*
  Compares one received UID byte with the matching byte of own UID.
  Assumes index is below the UID byte count.
*/
`default_nettype none
module rrf_uid_cmp
(
  // Compare inputs
  input  wire logic [63:0] own_uid,
  input  wire logic [3:0]  index,
  input  wire logic [7:0]  rx_byte,
  // Result
  output logic             equal
);
  logic [7:0] own_byte;
  always_comb
  begin
    own_byte = own_uid[{index[2:0], 3'h0} +: 8];
    equal    = (own_byte == rx_byte);
  end
endmodule // rrf_uid_cmp
`default_nettype wire

// File: src/rrf_framer.sv
/*
  Request flag decoder and response flag/error encoder of the
  contactless front end. Bytes arrive already deframed, LSB-first
  reassembled, with a start strobe at SOF and an end strobe at EOF.
  Assumes all inputs are on clk_sys; reset follows field loss.
*/
`default_nettype none
// Function
// RULE1: Request parsed as flags, command, parameters/data, CRC between delimiters.
// RULE2: Request flags held as eight bits; inventory bit steers upper nibble.
// RULE3: Inventory 0 gives selection meaning, 1 gives inventory meaning.
// RULE4: Flag bit 1 picks one or two reply subcarriers.
// RULE5: Flag bit 2 picks low or high reply data rate.
// RULE6: Reader always sends extension bit as zero.
// RULE7: Selected-only qualifier restricts execution to Selected state tag.
// RULE8: Addressing bit means UID follows; only matching tag executes.
// RULE9: Reader clears addressing bit and omits UID when selected-only set.
// RULE10: Inventory flag bit 5 marks an AFI byte present.
// RULE11: Whole flags byte captured before dependent fields are interpreted.
// RULE12: Response is flags, parameters/data, CRC between delimiters.
// RULE13: Response flags emitted as eight-bit field.
// RULE14: Response bit 1 set on error, then error code follows.
// RULE15: Response bits 2 to 8 always zero.
// RULE16: Error code byte present only with error bit.
// RULE17: Code 03h unsupported option, 0Fh unspecified error.
// RULE18: Code 10h missing block, 11h already locked.
// RULE19: Code 12h write to locked block, 13h programming failed.
// RULE20: Code 14h lock failed, 15h read protected.
// RULE21: No error code outside the listed set.
// RULE22: Inventory flag bit 6 picks sixteen slots or one slot.
// RULE23: Addressed request with foreign UID gets no response.
// RULE24: Flag bit N sits at byte bit N-1, LSB first.
module rrf_framer
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  // Received frame bytes
  input  wire logic                  rx_sof,
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_byte,
  input  wire logic                  rx_eof,
  // Tag context
  input  wire logic [63:0]           own_uid,
  input  wire logic                  tag_selected,
  // Response request from command logic
  input  wire logic                  resp_start,
  input  wire logic                  resp_error,
  input  wire rrf_pkg::rrf_cause_type resp_cause,
  // Decoded request
  output logic [7:0]                 req_flags,
  output logic [7:0]                 req_command,
  output logic                       flags_valid,
  output logic                       two_subcarriers,
  output logic                       high_rate,
  output logic                       inventory_mode,
  output logic                       select_only,
  output logic                       addressed,
  output logic                       option_set,
  output logic                       afi_present,
  output logic                       slot_count_select,
  output logic [4:0]                 slot_total,
  output logic [2:0]                 slot_number_bits,
  output logic [7:0]                 afi_value,
  output logic                       body_valid,
  output logic [7:0]                 body_byte,
  output logic                       req_done,
  output logic                       req_execute,
  // Response header
  output logic                       tx_valid,
  output logic [7:0]                 tx_flags,
  output logic                       tx_code_present,
  output logic [7:0]                 tx_code
);
  default clocking cb_chk @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Parse state
  rrf_pkg::rrf_state_type state, next_state;
  logic [7:0] next_req_flags, next_req_command, next_afi_value, next_body_byte;
  logic [3:0] uid_idx, next_uid_idx;
  logic       uid_match, next_uid_match;
  logic       next_flags_valid, next_body_valid, next_req_done, next_req_execute;
  logic       byte_equal, f_inv, f_sel, f_adr;
  rrf_uid_cmp u_uid_cmp
  (.own_uid(own_uid), .index(uid_idx), .rx_byte(rx_byte), .equal(byte_equal));
  assign f_inv = req_flags[rrf_pkg::INVENTORY_BIT];
  assign f_sel = req_flags[rrf_pkg::FLAG5_BIT];
  assign f_adr = req_flags[rrf_pkg::FLAG6_BIT];

  always_comb
  begin
    next_state       = state;
    next_req_flags   = req_flags;
    next_req_command = req_command;
    next_afi_value   = afi_value;
    next_body_byte   = body_byte;
    next_uid_idx     = uid_idx;
    next_uid_match   = uid_match;
    next_flags_valid = flags_valid;
    next_body_valid  = 1'b0;
    next_req_done    = 1'b0;
    next_req_execute = 1'b0;
    // A new SOF aborts any frame in progress
    if (rx_sof)
    begin
      next_state       = rrf_pkg::rrf_flags; // RULE1
      next_flags_valid = 1'b0;
      next_uid_idx     = rrf_pkg::IDX_ZERO;
      next_uid_match   = 1'b1;
    end
    else
    begin
      case (state)
        rrf_pkg::rrf_flags:
          if (rx_valid)
          begin
            next_req_flags   = rx_byte; // RULE2 RULE24
            next_flags_valid = 1'b1; // RULE11
            next_state       = rrf_pkg::rrf_cmd;
          end
        rrf_pkg::rrf_cmd:
          if (rx_valid)
          begin
            next_req_command = rx_byte;
            // Flags already held, so optional fields decide next step
            if (!f_inv && f_adr)
              next_state = rrf_pkg::rrf_uid; // RULE8 RULE11
            else if (f_inv && f_sel)
              next_state = rrf_pkg::rrf_afi; // RULE10
            else
              next_state = rrf_pkg::rrf_body;
          end
        rrf_pkg::rrf_uid:
          if (rx_valid)
          begin
            next_uid_match = uid_match & byte_equal; // RULE23
            next_uid_idx   = uid_idx + 4'h1;
            if (uid_idx == rrf_pkg::UID_LAST)
              next_state = rrf_pkg::rrf_body;
          end
        rrf_pkg::rrf_afi:
          if (rx_valid)
          begin
            next_afi_value = rx_byte; // RULE10
            next_state     = rrf_pkg::rrf_body;
          end
        rrf_pkg::rrf_body:
          if (rx_valid)
          begin
            // Parameters, data and CRC pass through; CRC check lives elsewhere
            next_body_byte  = rx_byte; // RULE1
            next_body_valid = 1'b1;
          end
        default:
          next_state = rrf_pkg::rrf_idle;
      endcase
      // A frame cut before the UID ends counts as no match
      if (rx_eof && state != rrf_pkg::rrf_idle)
      begin
        next_state    = rrf_pkg::rrf_idle;
        next_req_done = 1'b1;
        if (state == rrf_pkg::rrf_body)
          next_req_execute = f_inv
            || ((!f_sel || tag_selected) // RULE7
            && (!f_adr || uid_match)); // RULE8 RULE23
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state       <= rrf_pkg::rrf_idle;
      req_flags   <= rrf_pkg::BYTE_ZERO;
      req_command <= rrf_pkg::BYTE_ZERO;
      afi_value   <= rrf_pkg::BYTE_ZERO;
      body_byte   <= rrf_pkg::BYTE_ZERO;
      uid_idx     <= rrf_pkg::IDX_ZERO;
      uid_match   <= 1'b0;
      flags_valid <= 1'b0;
      body_valid  <= 1'b0;
      req_done    <= 1'b0;
      req_execute <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      req_flags   <= next_req_flags;
      req_command <= next_req_command;
      afi_value   <= next_afi_value;
      body_byte   <= next_body_byte;
      uid_idx     <= next_uid_idx;
      uid_match   <= next_uid_match;
      flags_valid <= next_flags_valid;
      body_valid  <= next_body_valid;
      req_done    <= next_req_done;
      req_execute <= next_req_execute;
    end
  end
  // ==========================================================
  // Flag decode, registered from the captured flags byte
  logic next_two_sub, next_high_rate, next_sel_only, next_addressed;
  logic next_afi_present, next_slot_sel;
  logic [4:0] next_slot_total;
  logic [2:0] next_slot_bits;
  always_comb
  begin
    next_two_sub     = next_req_flags[rrf_pkg::SUBCARRIER_BIT]; // RULE4
    next_high_rate   = next_req_flags[rrf_pkg::DATA_RATE_BIT]; // RULE5
    // Upper nibble meaning depends on the inventory bit
    next_sel_only    = !next_req_flags[rrf_pkg::INVENTORY_BIT]
                       && next_req_flags[rrf_pkg::FLAG5_BIT]; // RULE3 RULE7
    next_addressed   = !next_req_flags[rrf_pkg::INVENTORY_BIT]
                       && next_req_flags[rrf_pkg::FLAG6_BIT]; // RULE3 RULE8
    next_afi_present = next_req_flags[rrf_pkg::INVENTORY_BIT]
                       && next_req_flags[rrf_pkg::FLAG5_BIT]; // RULE3 RULE10
    next_slot_sel    = next_req_flags[rrf_pkg::INVENTORY_BIT]
                       && next_req_flags[rrf_pkg::FLAG6_BIT]; // RULE22
    next_slot_total  = next_slot_sel ? rrf_pkg::SLOTS_ONE : rrf_pkg::SLOTS_MANY;
    next_slot_bits   = next_slot_sel ? rrf_pkg::SLOT_BITS_ONE : rrf_pkg::SLOT_BITS_MANY; // RULE22
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      two_subcarriers   <= 1'b0;
      high_rate         <= 1'b0;
      inventory_mode    <= 1'b0;
      select_only       <= 1'b0;
      addressed         <= 1'b0;
      option_set        <= 1'b0;
      afi_present       <= 1'b0;
      slot_count_select <= 1'b0;
      slot_total        <= rrf_pkg::SLOTS_MANY;
      slot_number_bits  <= rrf_pkg::SLOT_BITS_MANY;
    end
    else
    begin
      two_subcarriers   <= next_two_sub;
      high_rate         <= next_high_rate;
      inventory_mode    <= next_req_flags[rrf_pkg::INVENTORY_BIT]; // RULE2
      select_only       <= next_sel_only;
      addressed         <= next_addressed;
      option_set        <= next_req_flags[rrf_pkg::OPTION_BIT];
      afi_present       <= next_afi_present;
      slot_count_select <= next_slot_sel;
      slot_total        <= next_slot_total;
      slot_number_bits  <= next_slot_bits;
    end
  end
  // ==========================================================
  // Response header
  logic [7:0] err_code, next_tx_flags, next_tx_code;
  logic       next_tx_valid, next_tx_code_present;
  rrf_err_encode u_err_encode
  (.cause(resp_cause), .code(err_code));
  always_comb
  begin
    next_tx_valid        = resp_start;
    next_tx_flags        = tx_flags;
    next_tx_code_present = tx_code_present;
    next_tx_code         = tx_code;
    if (resp_start)
    begin
      // Only the error bit may be set; everything else reads zero
      next_tx_flags = rrf_pkg::BYTE_ZERO; // RULE13 RULE15
      next_tx_flags[rrf_pkg::ERROR_BIT] = resp_error; // RULE14 RULE24
      next_tx_code_present = resp_error; // RULE16 RULE12
      next_tx_code = resp_error ? err_code : rrf_pkg::BYTE_ZERO; // RULE21
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      tx_valid        <= 1'b0;
      tx_flags        <= rrf_pkg::BYTE_ZERO;
      tx_code_present <= 1'b0;
      tx_code         <= rrf_pkg::BYTE_ZERO;
    end
    else
    begin
      tx_valid        <= next_tx_valid;
      tx_flags        <= next_tx_flags;
      tx_code_present <= next_tx_code_present;
      tx_code         <= next_tx_code;
    end
  end
  // ==========================================================
  // Checks
  sequence s_flags_byte;
    state == rrf_pkg::rrf_flags && rx_valid && !rx_sof;
  endsequence
  property p_flags_capture;
    s_flags_byte |=> req_flags == $past(rx_byte) && flags_valid;
  endproperty
  a_flags_capture: assert property (p_flags_capture) else $error("flags not captured"); // RULE2
  property p_resp_upper_zero;
    tx_valid |-> tx_flags[7:1] == 7'h00;
  endproperty
  a_resp_upper_zero: assert property (p_resp_upper_zero) else $error("reserved bit set"); // RULE15
  property p_err_bit;
    resp_start |=> tx_flags[0] == $past(resp_error) && tx_code_present == tx_flags[0];
  endproperty
  a_err_bit: assert property (p_err_bit) else $error("error bit wrong"); // RULE14
  property p_code_set;
    tx_valid && tx_code_present |-> tx_code inside {8'h03, 8'h0f, 8'h10, 8'h11,
      8'h12, 8'h13, 8'h14, 8'h15};
  endproperty
  a_code_set: assert property (p_code_set) else $error("code outside set"); // RULE21
  property p_select_mode;
    select_only |-> !inventory_mode && req_flags[4];
  endproperty
  a_select_mode: assert property (p_select_mode) else $error("select decode"); // RULE7
  property p_slots;
    flags_valid |-> slot_total == (slot_count_select ? 5'h01 : 5'h10);
  endproperty
  a_slots: assert property (p_slots) else $error("slot count wrong"); // RULE22
  property p_uid_silent;
    req_execute && addressed |-> uid_match;
  endproperty
  a_uid_silent: assert property (p_uid_silent) else $error("foreign uid executed"); // RULE23
  property p_afi_route;
    state == rrf_pkg::rrf_cmd && rx_valid && !rx_sof && !rx_eof && f_inv && f_sel
      |=> state == rrf_pkg::rrf_afi;
  endproperty
  a_afi_route: assert property (p_afi_route) else $error("afi skipped"); // RULE10
  property p_rate;
    ##1 (high_rate == req_flags[1] && two_subcarriers == req_flags[0]);
  endproperty
  a_rate: assert property (p_rate) else $error("rate decode"); // RULE5
endmodule // rrf_framer
`default_nettype wire

// File: tb/rrf_reader_model.sv
/*
  Reader-side model: sends request frames to the tag as byte strobes.
  Assumes the tag samples every strobe on the rising edge of clk_sys.
*/
`default_nettype none
module rrf_reader_model
(
  // Clock
  input  wire logic       clk_sys,
  // Frame bytes towards the tag
  output var  logic       rx_sof,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_eof
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    rx_sof   = 1'b0;
    rx_valid = 1'b0;
    rx_byte  = 8'h5a;
    rx_eof   = 1'b0;
  end

  // ==========================================================
  // One strobe set per cycle, launched on the rising edge
  task automatic put(input logic s, input logic v, input logic [7:0] b, input logic e);
    @(posedge clk_sys);
    rx_sof   <= s;
    rx_valid <= v;
    rx_byte  <= b;
    rx_eof   <= e;
  endtask

  // ==========================================================
  // b[0] flags, b[1] command, then optional fields and body
  task automatic frame(input logic [7:0] b[$]);
    logic [7:0] last;
    last    = 8'h00;
    b[0][3] = 1'b0;
    if (b[0][2] == 1'b0 && b[0][4] == 1'b1)
    begin
      b[0][5] = 1'b0;
    end
    put(1'b1, 1'b0, 8'h00, 1'b0);
    foreach (b[i])
    begin
      put(1'b0, 1'b1, b[i], 1'b0);
      last = b[i];
    end
    // Idle data line toggles so a stale byte is never reused
    put(1'b0, 1'b0, ~last, 1'b1);
    put(1'b0, 1'b0, last, 1'b0);
  endtask
endmodule // rrf_reader_model
`default_nettype wire

// File: tb/rrf_framer_tb.sv
/*
  Self-checking bench for the request/response flag framer.
  Assumes the reader model drives the receive strobes; the bench
  drives tag context and response requests.
*/
`default_nettype none
module rrf_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [63:0] UID = 64'h8877665544332211;
  logic                   clk_sys, rstn, rx_sof, rx_valid, rx_eof, tag_selected;
  logic [7:0]             rx_byte, req_flags, req_command, afi_value, body_byte;
  logic [7:0]             tx_flags, tx_code, last_body;
  logic [63:0]            own_uid;
  logic                   resp_start, resp_error;
  rrf_pkg::rrf_cause_type resp_cause;
  logic                   flags_valid, two_subcarriers, high_rate, inventory_mode;
  logic                   select_only, addressed, option_set, afi_present;
  logic                   slot_count_select, body_valid, req_done, req_execute;
  logic                   tx_valid, tx_code_present;
  logic [4:0]             slot_total;
  logic [2:0]             slot_number_bits;
  int                     bad_count, comparisons, body_cnt, cycles;
  logic [7:0]             q[$];
  logic [7:0]             codes [8];

  rrf_framer i_dut
  (
    .clk_sys(clk_sys), .rstn(rstn), .rx_sof(rx_sof), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_eof(rx_eof), .own_uid(own_uid), .tag_selected(tag_selected),
    .resp_start(resp_start), .resp_error(resp_error), .resp_cause(resp_cause),
    .req_flags(req_flags), .req_command(req_command), .flags_valid(flags_valid),
    .two_subcarriers(two_subcarriers), .high_rate(high_rate),
    .inventory_mode(inventory_mode), .select_only(select_only), .addressed(addressed),
    .option_set(option_set), .afi_present(afi_present),
    .slot_count_select(slot_count_select), .slot_total(slot_total),
    .slot_number_bits(slot_number_bits), .afi_value(afi_value),
    .body_valid(body_valid), .body_byte(body_byte), .req_done(req_done),
    .req_execute(req_execute), .tx_valid(tx_valid), .tx_flags(tx_flags),
    .tx_code_present(tx_code_present), .tx_code(tx_code)
  );

  rrf_reader_model i_reader
  (
    .clk_sys(clk_sys), .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_eof(rx_eof)
  );

  // ==========================================================
  // Clock, body byte monitor, hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    if (body_valid === 1'b1)
    begin
      body_cnt++;
      last_body = body_byte;
    end
    cycles++;
    // Whole run is about 90 cycles
    if (cycles == 3000)
    begin
      bad_count++;
      close_out();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] fl, input logic [7:0] cmd);
    body_cnt = 0;
    q.push_front(cmd);
    q.push_front(fl);
    i_reader.frame(q);
    #1;
    chk(req_done, 1'b1);
    chk(req_flags, fl);
    chk(req_command, cmd);
  endtask

  task automatic respond(input logic err, input rrf_pkg::rrf_cause_type c);
    @(posedge clk_sys);
    resp_start <= 1'b1;
    resp_error <= err;
    resp_cause <= c;
    @(posedge clk_sys);
    resp_start <= 1'b0;
    #1;
    chk(tx_valid, 1'b1);
    chk(tx_flags, {7'h00, err});
    chk(tx_code_present, err);
  endtask

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    codes = '{8'h03, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
    rstn = 1'b0;
    own_uid = UID;
    tag_selected = 1'b0;
    resp_start = 1'b0;
    resp_error = 1'b0;
    resp_cause = rrf_pkg::rrf_cause_generic;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk(slot_total, 5'h10);
    chk(slot_number_bits, 3'h4);
    chk(flags_valid, 1'b0);
    // Addressed, matching UID, one body byte
    q = {};
    for (int i = 0; i < 8; i++) q.push_back(UID[8*i +: 8]);
    q.push_back(8'ha5);
    send(8'h22, 8'h20);
    chk(req_execute, 1'b1);
    chk(high_rate, 1'b1);
    chk(addressed, 1'b1);
    chk(two_subcarriers, 1'b0);
    chk(inventory_mode, 1'b0);
    chk(body_cnt, 1);
    chk(last_body, 8'ha5);
    // Addressed, one UID byte differs
    q = {};
    for (int i = 0; i < 8; i++) q.push_back(UID[8*i +: 8] ^ {7'h00, i == 3});
    q.push_back(8'ha5);
    send(8'h22, 8'h20);
    chk(req_execute, 1'b0);
    // Selected-only, tag not selected, then selected
    q = {8'h00};
    send(8'h51, 8'h21);
    chk(req_execute, 1'b0);
    chk(select_only, 1'b1);
    chk(two_subcarriers, 1'b1);
    chk(option_set, 1'b1);
    chk(addressed, 1'b0);
    @(posedge clk_sys);
    tag_selected <= 1'b1;
    q = {8'h00};
    send(8'h51, 8'h21);
    chk(req_execute, 1'b1);
    // Inventory with AFI and sixteen slots
    q = {8'h5a, 8'h0b};
    send(8'h16, 8'h01);
    chk(inventory_mode, 1'b1);
    chk(select_only, 1'b0);
    chk(afi_present, 1'b1);
    chk(afi_value, 8'h5a);
    chk(body_cnt, 1);
    chk(last_body, 8'h0b);
    chk(slot_count_select, 1'b0);
    chk(slot_total, 5'h10);
    chk(slot_number_bits, 3'h4);
    // Inventory without AFI, single slot
    q = {8'hc3};
    send(8'h24, 8'h01);
    chk(afi_present, 1'b0);
    chk(last_body, 8'hc3);
    chk(slot_count_select, 1'b1);
    chk(slot_total, 5'h01);
    chk(slot_number_bits, 3'h0);
    // Frame cut inside the UID is never executed
    q = {UID[7:0], UID[15:8]};
    send(8'h22, 8'h20);
    chk(req_execute, 1'b0);
    chk(flags_valid, 1'b1);
    // Every error cause, one response request every other cycle
    for (int c = 0; c < 8; c++)
    begin
      respond(1'b1, rrf_pkg::rrf_cause_type'(c));
      chk(tx_code, codes[c]);
    end
    respond(1'b0, rrf_pkg::rrf_cause_locked);
    chk(tx_code, 8'h00);
    @(posedge clk_sys);
    #1;
    chk(tx_valid, 1'b0);
    chk(tx_flags, 8'h00);
    close_out();
  end
endmodule // rrf_framer_tb
`default_nettype wire
